// ---- verilog/pkt_cfg_pkg.sv ----
// Constants, state codes and register layout of the packet handler block
package pkt_cfg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PEAK = 8'h2E;
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_STAT = 8'h31;
	localparam logic [7:0] IDX_HCHK = 8'h32;
	localparam logic [7:0] IDX_FCFG = 8'h40;
	localparam logic [7:0] IDX_HBYTES = 8'h41;
	localparam logic [7:0] IDX_PKLEN = 8'h42;
	localparam logic [7:0] IDX_EVENTS = 8'h43;
	// Packet handling control fields
	localparam int CTRL_RXEN = 7;
	localparam int CTRL_LSB = 6;
	localparam int CTRL_DONLY = 5;
	localparam int CTRL_TXEN = 3;
	localparam int CTRL_CRCEN = 2;
	localparam int CTRL_POLY_LO = 0;
	// Status fields
	localparam int ST_ONES = 6;
	localparam int ST_SRCH = 5;
	localparam int ST_RX = 4;
	localparam int ST_VALID = 3;
	localparam int ST_CRCERR = 2;
	localparam int ST_TX = 1;
	localparam int ST_SENT = 0;
	// Header check control fields
	localparam int BCEN_LO = 4;
	localparam int HDCH_LO = 0;
	// Frame configuration fields
	localparam int FC_MODE_LO = 0;
	localparam int FC_FIXLEN = 3;
	localparam int FC_HDLEN_LO = 4;
	localparam int FC_RXON = 7;
	localparam int FC_TXGO = 8;
	// Reset values
	localparam logic [7:0] RST_PEAK = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_HCHK = 8'h00;
	localparam logic [7:0] RST_PKLEN = 8'h00;
	// Data mode, polynomials, CRC constants
	localparam logic [1:0] MODE_FIFO = 2'h2;
	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam logic [15:0] POLY_IBM = 16'h8005;
	localparam logic [15:0] POLY_IEC = 16'h3D65;
	localparam logic [15:0] POLY_BIA = 16'h8BB7;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] CRC_ONES = 16'hFFFF;
	localparam logic [7:0] BCAST = 8'hFF;
	// Framer states, shared by transmit and receive
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR = 3'b001,
		ST_LEN = 3'b010,
		ST_DATA = 3'b011,
		ST_CRC = 3'b100,
		ST_RAW = 3'b101,
		ST_DRAIN = 3'b110
	} fr_state_t;
endpackage

// ---- verilog/packet_handler_config.sv ----
// Packet handler: AHB-Lite registers, transmit framer, receive parser
`timescale 1ns/100ps
`default_nettype none
module packet_handler_config
	import pkt_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] tx_fifo_data,
	input wire logic tx_fifo_valid,
	output logic tx_fifo_pop,
	output logic tx_bit,
	output logic tx_bit_valid,
	input wire logic tx_bit_take,
	input wire logic rx_bit,
	input wire logic rx_bit_strobe,
	input wire logic rx_sync_found,
	input wire logic rx_frame_end,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid
);

	// Whole state of the block in one record
	typedef struct packed {
		logic [7:0] peak; // Slicer attack and decay, bit 7 kept
		logic [7:0] ctrl; // Packet handling control
		logic [7:0] hchk; // Broadcast and header check enables
		logic [1:0] mode; // Data mode select
		logic [2:0] hdlen; // Header length code
		logic fixlen; // Length byte left out of header
		logic rx_on; // Receiver running
		logic [31:0] hbytes; // Header bytes 3..0, sent and checked
		logic [7:0] pklen; // Transmit or fixed packet length
		logic ev_valid; // Latched valid packet
		logic ev_crcerr; // Latched CRC error
		logic ev_sent; // Latched packet sent
		logic crc_ones; // Last received CRC was all ones
		logic pend; // Bus data phase in progress
		logic pwrite; // Pending access is a write
		logic [7:0] pidx; // Pending register index
		logic ready; // Bus ready out
		logic resp; // Bus response, always OKAY
		logic [31:0] rdata; // Bus read data
		fr_state_t txs; // Transmit framer state
		logic [7:0] tsh; // Transmit shifter
		logic [3:0] tbits; // Bits left in shifter
		logic [1:0] tpos; // Next header byte position
		logic [2:0] tleft; // Header bytes left
		logic [7:0] tdcnt; // Data bytes left
		logic [15:0] tcrc; // Transmit CRC
		logic tlo; // Low CRC byte next
		logic tbit; // Bit on the line
		logic tbitv; // Bit on the line is valid
		logic tpop; // FIFO byte taken
		fr_state_t rxs; // Receive parser state
		logic [7:0] rsh; // Receive shifter
		logic [2:0] rbits; // Bits gathered in shifter
		logic [1:0] rpos; // Next header byte position
		logic [2:0] rleft; // Header bytes left
		logic [7:0] rdcnt; // Data bytes left
		logic [15:0] rcrc; // Running receive CRC
		logic [7:0] rhi; // High byte of received CRC
		logic rlo; // Low CRC byte expected
		logic [7:0] rout; // Byte towards receive FIFO
		logic rvalid; // Byte towards receive FIFO valid
	} state_t;

	state_t state_ff; // Registered state
	state_t nxt_state; // Next state
	logic go; // Transmit start from a config write
	logic clr_ev; // Event flags read
	logic set_valid; // Valid packet event
	logic set_err; // CRC error event
	logic set_sent; // Packet sent event
	logic fifo_mode; // FIFO data mode selected
	logic lsb; // LSB first on the line
	logic donly; // CRC over data field only
	logic crcen; // CRC enabled
	logic [15:0] poly; // Selected polynomial
	logic [7:0] stat; // Status register image
	logic tload; // Load transmit shifter
	logic tcrc_en; // Byte enters transmit CRC
	logic [7:0] tb; // Byte to transmit
	logic rhave; // Whole byte received
	logic rcrc_en; // Byte enters receive CRC
	logic [7:0] rb; // Received byte
	logic [15:0] rgot; // Received CRC value

	// CRC over one byte, MSB first regardless of line order
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d, input logic [15:0] p);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ p) : (r << 1);
		end
		return r;
	endfunction

	// Polynomial for the two-bit select code
	function automatic logic [15:0] sel_poly(input logic [1:0] sel);
		case (sel)
			2'h0: return POLY_CCITT;
			2'h1: return POLY_IBM;
			2'h2: return POLY_IEC;
			default: return POLY_BIA;
		endcase
	endfunction

	// Number of header bytes for a length code; codes above 4 mean 4
	function automatic logic [2:0] hdr_count(input logic [2:0] code);
		return (code > 3'h4) ? 3'h4 : code;
	endfunction

	// State after the length byte, or after the header when length fixed
	function automatic fr_state_t after_len(input logic [7:0] len,
		input logic ce);
		if (len != 8'h00)
			return ST_DATA;
		return ce ? ST_CRC : ST_DRAIN;
	endfunction

	// State after the last header byte
	function automatic fr_state_t after_hdr(input logic fl,
		input logic [7:0] len, input logic ce);
		return fl ? after_len(len, ce) : ST_LEN;
	endfunction

	// Header byte accepted if unchecked, matching, or enabled broadcast
	function automatic logic hdr_ok(input logic [7:0] b,
		input logic [1:0] pos, input logic [7:0] hc,
		input logic [31:0] hb);
		logic [7:0] ref_byte;
		ref_byte = hb[{pos, 3'b000} +: 8];
		return !hc[HDCH_LO + pos] || (b == ref_byte) ||
			(hc[BCEN_LO + pos] && (b == BCAST));
	endfunction

	// Next-state logic for bus, framer and parser
	always_comb
	begin
		nxt_state = state_ff;
		go = 1'b0;
		clr_ev = 1'b0;
		set_valid = 1'b0;
		set_err = 1'b0;
		set_sent = 1'b0;
		tload = 1'b0;
		tcrc_en = 1'b0;
		tb = 8'h00;
		rhave = 1'b0;
		rcrc_en = 1'b0;
		rb = 8'h00;
		rgot = 16'h0000;
		fifo_mode = (state_ff.mode == MODE_FIFO);
		lsb = state_ff.ctrl[CTRL_LSB];
		donly = state_ff.ctrl[CTRL_DONLY];
		crcen = state_ff.ctrl[CTRL_CRCEN];
		poly = sel_poly(state_ff.ctrl[CTRL_POLY_LO +: 2]);
		nxt_state.tpop = 1'b0;
		nxt_state.rvalid = 1'b0;

		// Live status bits and mirrored event flags
		stat = 8'h00;
		stat[ST_ONES] = state_ff.crc_ones;
		stat[ST_SRCH] = fifo_mode && state_ff.rx_on &&
			(state_ff.rxs == ST_IDLE);
		stat[ST_RX] = (state_ff.rxs != ST_IDLE);
		stat[ST_VALID] = state_ff.ev_valid;
		stat[ST_CRCERR] = state_ff.ev_crcerr;
		stat[ST_TX] = (state_ff.txs != ST_IDLE);
		stat[ST_SENT] = state_ff.ev_sent;

		// Bus: address phase latched, access done one cycle later
		if (state_ff.pend)
		begin
			nxt_state.pend = 1'b0;
			nxt_state.ready = 1'b1;
			if (state_ff.pwrite)
			begin
				case (state_ff.pidx)
					IDX_PEAK: nxt_state.peak = hwdata[7:0];
					IDX_CTRL: nxt_state.ctrl = hwdata[7:0];
					IDX_HCHK: nxt_state.hchk = hwdata[7:0];
					IDX_FCFG:
					begin
						nxt_state.mode = hwdata[FC_MODE_LO +: 2];
						nxt_state.fixlen = hwdata[FC_FIXLEN];
						nxt_state.hdlen = hwdata[FC_HDLEN_LO +: 3];
						nxt_state.rx_on = hwdata[FC_RXON];
						go = hwdata[FC_TXGO];
					end
					IDX_HBYTES: nxt_state.hbytes = hwdata;
					IDX_PKLEN: nxt_state.pklen = hwdata[7:0];
					default: ; // Unmapped or read-only: ignored
				endcase
			end
			else
			begin
				nxt_state.rdata = 32'h0000_0000;
				case (state_ff.pidx)
					IDX_PEAK: nxt_state.rdata[7:0] = state_ff.peak;
					IDX_CTRL: nxt_state.rdata[7:0] = state_ff.ctrl;
					IDX_STAT: nxt_state.rdata[7:0] = stat;
					IDX_HCHK: nxt_state.rdata[7:0] = state_ff.hchk;
					IDX_FCFG:
					begin
						nxt_state.rdata[FC_MODE_LO +: 2] = state_ff.mode;
						nxt_state.rdata[FC_FIXLEN] = state_ff.fixlen;
						nxt_state.rdata[FC_HDLEN_LO +: 3] = state_ff.hdlen;
						nxt_state.rdata[FC_RXON] = state_ff.rx_on;
					end
					IDX_HBYTES: nxt_state.rdata = state_ff.hbytes;
					IDX_PKLEN: nxt_state.rdata[7:0] = state_ff.pklen;
					IDX_EVENTS:
					begin
						// Only this read clears the latched events
						nxt_state.rdata[ST_VALID] = state_ff.ev_valid;
						nxt_state.rdata[ST_CRCERR] = state_ff.ev_crcerr;
						nxt_state.rdata[ST_SENT] = state_ff.ev_sent;
						clr_ev = 1'b1;
					end
					default: ; // Unmapped reads as zero
				endcase
			end
		end
		else if (hsel && htrans[1] && hready)
		begin
			nxt_state.pend = 1'b1;
			nxt_state.ready = 1'b0;
			nxt_state.pwrite = hwrite;
			// High address bits must be zero, else nothing decodes
			nxt_state.pidx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
		end

		// Transmit: shift out, then fetch next byte once shifter empty
		if (state_ff.tbits != 4'h0)
		begin
			if (tx_bit_take)
			begin
				nxt_state.tsh = lsb ? (state_ff.tsh >> 1) :
					(state_ff.tsh << 1);
				nxt_state.tbits = state_ff.tbits - 4'h1;
			end
		end
		else
		begin
			case (state_ff.txs)
				ST_IDLE:
				begin
					if (go && (nxt_state.mode == MODE_FIFO))
					begin
						nxt_state.tcrc = CRC_INIT;
						nxt_state.tlo = 1'b0;
						nxt_state.tpos = 2'h3;
						nxt_state.tleft = hdr_count(nxt_state.hdlen);
						nxt_state.tdcnt = state_ff.pklen;
						if (!state_ff.ctrl[CTRL_TXEN])
							nxt_state.txs = ST_RAW;
						else if (hdr_count(nxt_state.hdlen) != 3'h0)
							nxt_state.txs = ST_HDR;
						else
							nxt_state.txs = after_hdr(nxt_state.fixlen,
								state_ff.pklen, crcen);
					end
				end
				ST_HDR:
				begin
					tb = state_ff.hbytes[{state_ff.tpos, 3'b000} +: 8];
					tload = 1'b1;
					tcrc_en = !donly;
					nxt_state.tpos = state_ff.tpos - 2'h1;
					nxt_state.tleft = state_ff.tleft - 3'h1;
					if (state_ff.tleft == 3'h1)
						nxt_state.txs = after_hdr(state_ff.fixlen,
							state_ff.pklen, crcen);
				end
				ST_LEN:
				begin
					tb = state_ff.pklen;
					tload = 1'b1;
					tcrc_en = !donly;
					nxt_state.txs = after_len(state_ff.pklen, crcen);
				end
				ST_DATA:
				begin
					if (tx_fifo_valid)
					begin
						tb = tx_fifo_data;
						tload = 1'b1;
						tcrc_en = 1'b1;
						nxt_state.tpop = 1'b1;
						nxt_state.tdcnt = state_ff.tdcnt - 8'h01;
						if (state_ff.tdcnt == 8'h01)
							nxt_state.txs = crcen ? ST_CRC : ST_DRAIN;
					end
				end
				ST_CRC:
				begin
					tb = state_ff.tlo ? state_ff.tcrc[7:0] :
						state_ff.tcrc[15:8];
					tload = 1'b1;
					nxt_state.tlo = !state_ff.tlo;
					if (state_ff.tlo)
						nxt_state.txs = ST_DRAIN;
				end
				ST_RAW:
				begin
					// Raw send: FIFO bytes only, ends when FIFO runs dry
					if (tx_fifo_valid)
					begin
						tb = tx_fifo_data;
						tload = 1'b1;
						nxt_state.tpop = 1'b1;
					end
					else
						nxt_state.txs = ST_DRAIN;
				end
				ST_DRAIN:
				begin
					set_sent = 1'b1;
					nxt_state.txs = ST_IDLE;
				end
				default: nxt_state.txs = ST_IDLE;
			endcase
		end
		if (tload)
		begin
			nxt_state.tsh = tb;
			nxt_state.tbits = 4'h8;
			if (tcrc_en)
				nxt_state.tcrc = crc_byte(state_ff.tcrc, tb, poly);
		end
		nxt_state.tbit = lsb ? nxt_state.tsh[0] : nxt_state.tsh[7];
		nxt_state.tbitv = (nxt_state.tbits != 4'h0);

		// Receive: wait for sync, gather bits into bytes
		if (state_ff.rxs == ST_IDLE)
		begin
			if (rx_sync_found && fifo_mode && state_ff.rx_on)
			begin
				nxt_state.rcrc = CRC_INIT;
				nxt_state.rbits = 3'h0;
				nxt_state.rlo = 1'b0;
				nxt_state.rpos = 2'h3;
				nxt_state.rleft = hdr_count(state_ff.hdlen);
				nxt_state.rdcnt = state_ff.pklen;
				if (!state_ff.ctrl[CTRL_RXEN])
					nxt_state.rxs = ST_RAW;
				else if (hdr_count(state_ff.hdlen) != 3'h0)
					nxt_state.rxs = ST_HDR;
				else
					nxt_state.rxs = after_hdr(state_ff.fixlen,
						state_ff.pklen, crcen);
			end
		end
		else if (rx_frame_end)
			nxt_state.rxs = ST_IDLE;
		else if (rx_bit_strobe)
		begin
			rb = lsb ? {rx_bit, state_ff.rsh[7:1]} :
				{state_ff.rsh[6:0], rx_bit};
			nxt_state.rsh = rb;
			nxt_state.rbits = state_ff.rbits + 3'h1;
			rhave = (state_ff.rbits == 3'h7);
		end
		if (rhave)
		begin
			case (state_ff.rxs)
				ST_HDR:
				begin
					rcrc_en = !donly;
					// A rejected header byte drops the packet
					if (!hdr_ok(rb, state_ff.rpos, state_ff.hchk,
						state_ff.hbytes))
						nxt_state.rxs = ST_IDLE;
					else
					begin
						nxt_state.rpos = state_ff.rpos - 2'h1;
						nxt_state.rleft = state_ff.rleft - 3'h1;
						if (state_ff.rleft == 3'h1)
							nxt_state.rxs = after_hdr(state_ff.fixlen,
								state_ff.pklen, crcen);
					end
				end
				ST_LEN:
				begin
					rcrc_en = !donly;
					nxt_state.rdcnt = rb;
					nxt_state.rxs = after_len(rb, crcen);
				end
				ST_DATA:
				begin
					rcrc_en = 1'b1;
					nxt_state.rout = rb;
					nxt_state.rvalid = 1'b1;
					nxt_state.rdcnt = state_ff.rdcnt - 8'h01;
					if (state_ff.rdcnt == 8'h01)
						nxt_state.rxs = crcen ? ST_CRC : ST_DRAIN;
				end
				ST_CRC:
				begin
					if (!state_ff.rlo)
					begin
						nxt_state.rhi = rb;
						nxt_state.rlo = 1'b1;
					end
					else
					begin
						rgot = {state_ff.rhi, rb};
						nxt_state.crc_ones = (rgot == CRC_ONES);
						if (rgot != state_ff.rcrc)
							set_err = 1'b1;
						else
							set_valid = 1'b1;
						nxt_state.rxs = ST_IDLE;
					end
				end
				ST_RAW:
				begin
					nxt_state.rout = rb;
					nxt_state.rvalid = 1'b1;
				end
				default: ;
			endcase
		end
		if (rcrc_en)
			nxt_state.rcrc = crc_byte(state_ff.rcrc, rb, poly);
		// Packet ended without CRC: valid as it stands
		if (nxt_state.rxs == ST_DRAIN)
		begin
			set_valid = 1'b1;
			nxt_state.rxs = ST_IDLE;
		end

		// Events: a new event wins over a clear in the same cycle
		nxt_state.ev_valid = (state_ff.ev_valid && !clr_ev) || set_valid;
		nxt_state.ev_crcerr = (state_ff.ev_crcerr && !clr_ev) || set_err;
		nxt_state.ev_sent = (state_ff.ev_sent && !clr_ev) || set_sent;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= '0;
			state_ff.peak <= RST_PEAK;
			state_ff.ctrl <= RST_CTRL;
			state_ff.hchk <= RST_HCHK;
			state_ff.pklen <= RST_PKLEN;
			state_ff.ready <= 1'b1;
		end
		else
			state_ff <= nxt_state;
	end

	// Outputs straight from the state register
	assign hreadyout = state_ff.ready;
	assign hresp = state_ff.resp;
	assign hrdata = state_ff.rdata;
	assign tx_fifo_pop = state_ff.tpop;
	assign tx_bit = state_ff.tbit;
	assign tx_bit_valid = state_ff.tbitv;
	assign rx_byte = state_ff.rout;
	assign rx_byte_valid = state_ff.rvalid;

endmodule
`default_nettype wire

// ---- testbench/packet_handler_config_sva.sv ----
// Checker for the packet handler's bus and link ports
`timescale 1ns/100ps
`default_nettype none
module packet_handler_config_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic tx_fifo_valid,
	input wire logic tx_fifo_pop,
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	input wire logic tx_bit_take,
	input wire logic rx_bit_strobe,
	input wire logic rx_byte_valid
);
	// One clock domain, bus reset disables all checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Status reads are plain bus reads; never an error reply
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus reply not okay");
	// Exactly one wait state per accepted transfer
	property p_wait;
		hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait state count wrong");
	// Read data holds between completions
	property p_hold;
		hreadyout && $past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved at rest");
	// FIFO advance is a single pulse
	property p_pop;
		tx_fifo_pop |=> !tx_fifo_pop;
	endproperty
	a_pop: assert property (p_pop)
		else $error("pop longer than one cycle");
	// A byte is taken only from a non-empty FIFO
	property p_popv;
		tx_fifo_pop |-> $past(tx_fifo_valid);
	endproperty
	a_popv: assert property (p_popv)
		else $error("pop from empty fifo");
	// A line bit stands until the modem takes it
	property p_stand;
		tx_bit_valid && !tx_bit_take |=> tx_bit_valid && $stable(tx_bit);
	endproperty
	a_stand: assert property (p_stand)
		else $error("line bit dropped before take");
	// Receive byte strobe is one cycle wide
	property p_rxv;
		rx_byte_valid |=> !rx_byte_valid;
	endproperty
	a_rxv: assert property (p_rxv)
		else $error("byte strobe too long");
	// A received byte follows a strobed bit
	property p_rxc;
		rx_byte_valid |-> $past(rx_bit_strobe);
	endproperty
	a_rxc: assert property (p_rxc)
		else $error("byte without a bit");
	// Main traffic seen
	c_bus: cover property (!hreadyout);
	c_pop: cover property (tx_fifo_pop);
	c_rx: cover property (rx_byte_valid);
endmodule
bind packet_handler_config packet_handler_config_chk chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.tx_fifo_valid(tx_fifo_valid), .tx_fifo_pop(tx_fifo_pop),
	.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
	.tx_bit_take(tx_bit_take), .rx_bit_strobe(rx_bit_strobe),
	.rx_byte_valid(rx_byte_valid));
`default_nettype wire

// ---- testbench/remote_radio_model.sv ----
// Far radio: catches line bits, sends synced bit frames
`timescale 1ns/100ps
`default_nettype none
module remote_radio_model (
	input wire logic hclk,
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	input wire logic slow,
	output logic tx_bit_take,
	output logic rx_bit,
	output logic rx_bit_strobe,
	output logic rx_sync_found,
	output logic rx_frame_end
);
	logic bits_q[$]; // Bits caught off the air
	logic [1:0] pace; // Divider for the slow modem
	// Quiet line at start
	initial
	begin
		tx_bit_take = 1'b0;
		rx_bit = 1'b0;
		rx_bit_strobe = 1'b0;
		rx_sync_found = 1'b0;
		rx_frame_end = 1'b0;
		pace = 2'h0;
	end
	// Take every cycle, or one in three to stall the sender
	always @(posedge hclk)
	begin
		if (tx_bit_valid && tx_bit_take)
			bits_q.push_back(tx_bit);
		pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
		tx_bit_take <= !slow || pace == 2'h1;
	end
	// Sync pulse, strobed bits, then carrier loss
	task automatic send(input logic [7:0] fr[$], input logic lsb);
		int i;
		int k;
		logic b;
		rx_sync_found <= 1'b1;
		@(posedge hclk);
		rx_sync_found <= 1'b0;
		for (i = 0; i < fr.size(); i++)
			for (k = 0; k < 8; k++)
			begin
				b = lsb ? fr[i][k] : fr[i][7 - k];
				rx_bit <= b;
				rx_bit_strobe <= 1'b1;
				@(posedge hclk);
				// Unstrobed line shows junk, not the held bit
				rx_bit <= ~b;
				rx_bit_strobe <= 1'b0;
				@(posedge hclk);
			end
		@(posedge hclk);
		rx_frame_end <= 1'b1;
		@(posedge hclk);
		rx_frame_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/packet_handler_config_tb.sv ----
// Self-checking bench for the packet handler block
`timescale 1ns/100ps
`default_nettype none
module packet_handler_config_tb;
	import pkt_cfg_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [7:0] tx_fifo_data, rx_byte;
	logic tx_fifo_valid, tx_fifo_pop, tx_bit, tx_bit_valid, tx_bit_take;
	logic rx_bit, rx_bit_strobe, rx_sync_found, rx_frame_end;
	logic rx_byte_valid, slow;
	logic [7:0] fq[$]; // Transmit FIFO contents
	logic [7:0] rq[$]; // Bytes handed to the receive FIFO
	int error_cnt, cmp_count, wd;
	assign hready = hreadyout; // Single slave
	packet_handler_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_fifo_data(tx_fifo_data),
		.tx_fifo_valid(tx_fifo_valid), .tx_fifo_pop(tx_fifo_pop),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
		.tx_bit_take(tx_bit_take), .rx_bit(rx_bit),
		.rx_bit_strobe(rx_bit_strobe), .rx_sync_found(rx_sync_found),
		.rx_frame_end(rx_frame_end), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid));
	remote_radio_model rr (.hclk(hclk), .tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid), .slow(slow), .tx_bit_take(tx_bit_take),
		.rx_bit(rx_bit), .rx_bit_strobe(rx_bit_strobe),
		.rx_sync_found(rx_sync_found), .rx_frame_end(rx_frame_end));
	// 50 ns clock
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// FIFO head refreshed each edge; empty shows a junk pattern
	always @(posedge hclk)
	begin
		if (tx_fifo_pop && fq.size() > 0)
			fq.delete(0);
		tx_fifo_valid <= fq.size() > 0;
		tx_fifo_data <= fq.size() > 0 ? fq[0] : 8'h5A;
		if (rx_byte_valid)
			rq.push_back(rx_byte);
		wd <= wd + 1;
		if (wd == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	// Verdict
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// One AHB-Lite single word transfer; waits on hready only
	task automatic bus(input logic [7:0] ix, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {22'h000000, ix, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [31:0] d);
		logic [31:0] r;
		bus(ix, 1'b1, d, r);
	endtask
	// Reference CRC, bytewise MSB first
	function automatic logic [15:0] crc(input logic [7:0] b[$],
		input logic [1:0] s);
		logic [15:0] c;
		logic [15:0] p;
		c = CRC_INIT;
		case (s)
			2'h0: p = POLY_CCITT;
			2'h1: p = POLY_IBM;
			2'h2: p = POLY_IEC;
			default: p = POLY_BIA;
		endcase
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? p : 16'h0000);
		return c;
	endfunction
	// Byte k of what the far radio caught
	function automatic logic [7:0] pbyte(input int k, input logic lsb);
		logic [7:0] b;
		for (int j = 0; j < 8; j++)
			b[lsb ? j : 7 - j] = rr.bits_q[8 * k + j];
		return b;
	endfunction
	// Ctrl reset value, peak read-write, read-only status, unmapped space
	task automatic t_regs();
		logic [31:0] v;
		bus(IDX_CTRL, 1'b0, 32'h0, v);
		chk("ctrl reset", 32'(RST_CTRL), v);
		wr(IDX_PEAK, 32'hFFFFFFA5);
		bus(IDX_PEAK, 1'b0, 32'h0, v);
		chk("peak rw", 32'h000000A5, v);
		wr(IDX_STAT, 32'h000000FF);
		bus(IDX_STAT, 1'b0, 32'h0, v);
		chk("status ro", 32'h0, v);
		wr(8'h3F, 32'h12345678);
		bus(8'h3F, 1'b0, 32'h0, v);
		chk("unmapped", 32'h0, v);
		$display("register test done");
	endtask
	// Framed sends over every polynomial, order, scope; last without CRC
	task automatic t_tx();
		logic [7:0] f[$];
		logic [15:0] c;
		logic [31:0] v;
		int n;
		for (int i = 0; i < 5; i++)
		begin
			f = '{8'h44, 8'h33, 8'h02, 8'hA1 + i[7:0], 8'h5B};
			c = i[1] ? crc(f[3:4], i[1:0]) : crc(f, i[1:0]);
			n = i < 4 ? 56 : 40;
			fq = f[3:4];
			rr.bits_q.delete();
			slow <= i[0];
			wr(IDX_CTRL, {24'h0, 1'b0, i[0], i[1], 2'h1, i < 4, i[1:0]});
			wr(IDX_HBYTES, 32'h44332211);
			wr(IDX_PKLEN, 32'h2);
			wr(IDX_FCFG, 32'h122);
			bus(IDX_STAT, 1'b0, 32'h0, v);
			chk("tx busy", 32'h1, 32'(v[ST_TX]));
			for (int k = 0; k < 3000 && rr.bits_q.size() < n; k++)
				@(posedge hclk);
			repeat (20) @(posedge hclk);
			chk("tx bits", 32'(n), 32'(rr.bits_q.size()));
			f.push_back(c[15:8]);
			f.push_back(c[7:0]);
			for (int k = 0; k < n / 8; k++)
				chk("tx byte", 32'(f[k]), 32'(pbyte(k, i[0])));
			bus(IDX_STAT, 1'b0, 32'h0, v);
			chk("sent", 32'h1, {30'h0, v[ST_TX], v[ST_SENT]});
			bus(IDX_STAT, 1'b0, 32'h0, v);
			chk("sent kept", 32'h1, 32'(v[ST_SENT]));
			bus(IDX_EVENTS, 1'b0, 32'h0, v);
			bus(IDX_STAT, 1'b0, 32'h0, v);
			chk("sent clear", 32'h0, 32'(v[ST_SENT]));
		end
		$display("framed transmit test done");
	endtask
	// Raw send: FIFO bytes only
	task automatic t_rawtx();
		rr.bits_q.delete();
		fq = '{8'h5C, 8'h3E};
		wr(IDX_CTRL, 32'h0);
		wr(IDX_FCFG, 32'h102);
		repeat (120) @(posedge hclk);
		chk("raw bits", 32'd16, 32'(rr.bits_q.size()));
		chk("raw data", 32'h5C3E, {16'h0, pbyte(0, 0), pbyte(1, 0)});
		$display("raw transmit test done");
	endtask
	// Parsed receive: good, broadcast, dropped, bad CRC, all-ones CRC
	task automatic t_rx();
		logic [7:0] f[$];
		logic [15:0] c;
		logic [31:0] v;
		wr(IDX_CTRL, 32'h84);
		wr(IDX_HCHK, 32'h13);
		wr(IDX_FCFG, 32'hC2);
		for (int i = 0; i < 5; i++)
		begin
			f = '{8'h44, 8'h33, i == 2 ? 8'hFF : 8'h22,
				i == 1 ? 8'hFF : 8'h11, 8'h02, 8'h6D, 8'h0F};
			c = i == 4 ? CRC_ONES : crc(f, 2'h0) ^ (i == 3 ? 16'h1 : 16'h0);
			f.push_back(c[15:8]);
			f.push_back(c[7:0]);
			bus(IDX_EVENTS, 1'b0, 32'h0, v);
			rq.delete();
			fork
				rr.send(f, 1'b0);
				begin
					repeat (40) @(posedge hclk);
					bus(IDX_STAT, 1'b0, 32'h0, v);
				end
			join
			chk("receiving", 32'h1, 32'(v[ST_RX]));
			bus(IDX_STAT, 1'b0, 32'h0, v);
			chk("rx status", 32'({i == 4, 2'h2, i < 2, i > 2, 2'h0}), v);
			chk("rx count", i == 2 ? 32'h0 : 32'h2, 32'(rq.size()));
			if (i != 2)
				chk("rx data", 32'h6D0F, {16'h0, rq[0], rq[1]});
		end
		$display("parsed receive test done");
	endtask
	// Fixed length, one header byte, LSB first, CRC on data only
	task automatic t_fixrx();
		logic [7:0] f[$];
		logic [15:0] c;
		logic [31:0] v;
		c = crc('{8'h6D, 8'h0F}, 2'h1);
		f = '{8'h44, 8'h6D, 8'h0F, c[15:8], c[7:0]};
		wr(IDX_CTRL, 32'hE5);
		wr(IDX_PKLEN, 32'h2);
		wr(IDX_FCFG, 32'h9A);
		bus(IDX_EVENTS, 1'b0, 32'h0, v);
		rq.delete();
		rr.send(f, 1'b1);
		bus(IDX_STAT, 1'b0, 32'h0, v);
		chk("fix rx status", 32'h28, v);
		chk("fix rx count", 32'h2, 32'(rq.size()));
		chk("fix rx data", 32'h6D0F, {16'h0, rq[0], rq[1]});
		$display("fixed length receive test done");
	endtask
	// Raw receive: every byte after sync
	task automatic t_rawrx();
		wr(IDX_CTRL, 32'h0);
		rq.delete();
		rr.send('{8'h3C, 8'h96, 8'h01}, 1'b0);
		repeat (4) @(posedge hclk);
		chk("raw rx count", 32'h3, 32'(rq.size()));
		chk("raw rx data", 32'h3C9601, {8'h0, rq[0], rq[1], rq[2]});
		$display("raw receive test done");
	endtask
	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		slow = 1'b0;
		tx_fifo_valid = 1'b0;
		tx_fifo_data = 8'h00;
		error_cnt = 0;
		cmp_count = 0;
		wd = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_tx();
		t_rawtx();
		t_rx();
		t_fixrx();
		t_rawrx();
		close_out();
	end
endmodule
`default_nettype wire
